// >>> core/pcio_consts.svh
// offsets, field masks and reset values of the coupled io ports
`ifndef PCIO_CONSTS_SVH
`define PCIO_CONSTS_SVH
`define PCIO_R_PIN     4'h0
`define PCIO_R_DOUT    4'h1
`define PCIO_R_OCELL   4'h2
`define PCIO_R_MASK    4'h3
`define PCIO_R_ICELL   4'h4
`define PCIO_R_ENRB    4'h5
`define PCIO_R_MODE    4'h6
`define PCIO_R_DIR     4'h7
`define PCIO_R_DRIVE   4'h8
`define PCIO_PORT_A    2'h0
`define PCIO_PORT_B    2'h1
`define PCIO_PORT_C    2'h2
`define PCIO_PORT_D    2'h3
`define PCIO_VALID     32'h06ffffff
`define PCIO_OD_MASK   32'h009cf0f0
`define PCIO_SLEW_MASK 32'h06000f0f
`define PCIO_RST_BYTE  8'h00
`endif

// >>> core/pcio_pkg.sv
// types of the coupled io ports
package pcio_pkg;
  typedef struct packed {
    logic [3:0][7:0] sync1;
    logic [3:0][7:0] sync2;
    logic [3:0][7:0] dout;
    logic [3:0][7:0] dir;
    logic [3:0][7:0] drive;
    logic [3:0][7:0] oe_q;
    logic [3:0][7:0] out_q;
    logic [3:0][7:0] od_q;
    logic [3:0][7:0] fast_q;
    logic [1:0][7:0] mode;
    logic [2:0][7:0] mask;
    logic [2:0][7:0] icell;
    logic [1:0][7:0] grp;
    logic [1:0]      msel_s;
    logic [7:0]      rdata;
    logic            rvalid;
    logic [7:0]      pd_la;
  } pcio_state_t;
endpackage

// >>> core/pcio_ports.sv
// four coupled io ports with macrocells, chip selects and register access
`timescale 1ns/1ps
`include "pcio_consts.svh"
module pcio_ports
  import pcio_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  reg_rd,
  input  wire logic                  reg_wr,
  input  wire logic [5:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  output logic                       reg_rvalid,
  input  wire logic                  msel_in,
  input  wire logic [3:0][7:0]       pin_in,
  output logic      [3:0][7:0]       pin_out,
  output logic      [3:0][7:0]       pin_oe,
  output logic      [3:0][7:0]       pin_od,
  output logic      [3:0][7:0]       pin_fast,
  input  wire logic [3:0][7:0]       la_oe,
  input  wire logic [3:0][7:0]       la_sel,
  input  wire logic [7:0]            latched_addr,
  input  wire logic                  cell_route_ab,
  input  wire logic                  cell_route_bc,
  input  wire logic [1:0][7:0]       cell_d,
  input  wire logic [1:0][7:0]       cell_ld,
  input  wire logic [2:0][7:0]       icell_ld,
  input  wire logic [1:0]            ecs_term,
  input  wire logic [1:0]            ecs_pol,
  output logic      [1:0][7:0]       cell_q,
  output logic      [2:0][7:0]       icell_q,
  output logic      [7:0]            pd_la
);

  localparam logic [31:0] VALID = `PCIO_VALID;
  localparam logic [31:0] OD_M  = `PCIO_OD_MASK;
  localparam logic [31:0] SLW_M = `PCIO_SLEW_MASK;

  pcio_state_t       s_reg;
  pcio_state_t       s_next;
  logic [3:0][7:0]   oe_e;
  logic [3:0][7:0]   dat;
  logic [2:0][7:0]   cv;
  logic [7:0]        wd;
  logic [7:0]        vm;
  logic [1:0]        pp;
  logic [3:0]        ra;
  logic              acc_rd;
  logic              acc_wr;
  logic              tg0;
  logic              tg1;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_next = s_reg;
    pp     = reg_addr[5:4];
    ra     = reg_addr[3:0];
    vm     = VALID[8*pp +: 8];
    wd     = reg_wdata & vm;
    acc_rd = reg_rd & ~s_reg.msel_s[1];
    acc_wr = reg_wr & ~s_reg.msel_s[1];
    s_next.msel_s = {s_reg.msel_s[0], msel_in};
    // cell group routing onto ports
    cv[0] = cell_route_ab ? 8'h00 : s_reg.grp[0];
    cv[1] = cell_route_ab ? s_reg.grp[0] : (cell_route_bc ? 8'h00 : s_reg.grp[1]);
    cv[2] = cell_route_bc ? s_reg.grp[1] : 8'h00;
    tg0 = (pp == `PCIO_PORT_A && !cell_route_ab) || (pp == `PCIO_PORT_B && cell_route_ab);
    tg1 = (pp == `PCIO_PORT_B && !cell_route_ab && !cell_route_bc) ||
          (pp == `PCIO_PORT_C && cell_route_bc);
    // array loads of the cell groups
    for (int g = 0; g < 2; g++) begin
      s_next.grp[g] = (s_reg.grp[g] & ~cell_ld[g]) | (cell_d[g] & cell_ld[g]);
    end
    for (int p = 0; p < 4; p++) begin
      s_next.sync1[p] = pin_in[p];
      s_next.sync2[p] = s_reg.sync1[p];
      oe_e[p] = (s_reg.dir[p] | la_oe[p]) & VALID[8*p +: 8];
      dat[p]  = s_reg.dout[p];
      if (p < 2) begin
        for (int b = 0; b < 8; b++) begin
          if (s_reg.mode[p[0]][b]) begin
            dat[p][b] = latched_addr[b];
          end else if (la_sel[p][b]) begin
            dat[p][b] = cv[p[0]][b];
          end else begin
            dat[p][b] = s_reg.dout[p][b];
          end
        end
      end else if (p == 2) begin
        dat[p] = (s_reg.dout[2] & ~la_sel[2]) | (cv[2] & la_sel[2]);
      end else begin
        dat[p] = s_reg.dout[p];
        if (la_sel[3][1]) begin
          dat[p][1] = ecs_pol[0] ? ecs_term[0] : ~ecs_term[0];
        end
        if (la_sel[3][2]) begin
          dat[p][2] = ecs_pol[1] ? ecs_term[1] : ~ecs_term[1];
        end
      end
      dat[p] = dat[p] & VALID[8*p +: 8];
      s_next.out_q[p]  = dat[p];
      s_next.od_q[p]   = s_reg.drive[p] & OD_M[8*p +: 8];
      s_next.fast_q[p] = s_reg.drive[p] & SLW_M[8*p +: 8];
      // open drain pins release instead of driving high
      s_next.oe_q[p] = oe_e[p] & ~(s_next.od_q[p] & dat[p]);
    end
    for (int p = 0; p < 3; p++) begin
      s_next.icell[p] = (s_reg.icell[p] & ~icell_ld[p]) |
                        (s_reg.sync2[p] & icell_ld[p]);
    end
    s_next.pd_la = s_reg.sync2[3] & VALID[31:24];
    // register writes
    if (acc_wr) begin
      unique case (ra)
        `PCIO_R_DOUT: s_next.dout[pp] = wd;
        `PCIO_R_DIR: s_next.dir[pp] = wd;
        `PCIO_R_DRIVE: s_next.drive[pp] = wd;
        `PCIO_R_MODE: begin
          if (pp < 2) begin
            s_next.mode[pp[0]] = wd;
          end
        end
        `PCIO_R_MASK: begin
          if (pp < 3) begin
            s_next.mask[pp] = wd;
          end
        end
        `PCIO_R_OCELL: begin
          if (tg0) begin
            s_next.grp[0] = (s_next.grp[0] & s_reg.mask[pp]) | (wd & ~s_reg.mask[pp]);
          end
          if (tg1) begin
            s_next.grp[1] = (s_next.grp[1] & s_reg.mask[pp]) | (wd & ~s_reg.mask[pp]);
          end
        end
        default: begin
        end
      endcase
    end
    // register reads
    s_next.rvalid = acc_rd;
    s_next.rdata  = 8'h00;
    if (acc_rd) begin
      unique case (ra)
        `PCIO_R_PIN: s_next.rdata = s_reg.sync2[pp] & vm;
        `PCIO_R_DOUT: s_next.rdata = s_reg.dout[pp];
        `PCIO_R_DIR: s_next.rdata = s_reg.dir[pp];
        `PCIO_R_DRIVE: s_next.rdata = s_reg.drive[pp];
        `PCIO_R_MODE: s_next.rdata = (pp < 2) ? s_reg.mode[pp[0]] : 8'h00;
        `PCIO_R_OCELL: s_next.rdata = (pp < 3) ? cv[pp] : 8'h00;
        `PCIO_R_MASK: s_next.rdata = (pp < 3) ? s_reg.mask[pp] : 8'h00;
        `PCIO_R_ICELL: s_next.rdata = (pp < 3) ? s_reg.icell[pp] : 8'h00;
        `PCIO_R_ENRB: s_next.rdata = (pp < 3) ? oe_e[pp] : 8'h00;
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata  = s_reg.rdata;
  assign reg_rvalid = s_reg.rvalid;
  assign pin_out    = s_reg.out_q;
  assign pin_oe     = s_reg.oe_q;
  assign pin_od     = s_reg.od_q;
  assign pin_fast   = s_reg.fast_q;
  assign cell_q     = s_reg.grp;
  assign icell_q    = s_reg.icell;
  assign pd_la      = s_reg.pd_la;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_oe_or;
    @(posedge clk) disable iff (srst)
      (s_reg.dir[2][0] || la_oe[2][0]) |=> pin_oe[2][0];
  endproperty
  a_oe_or: assert property (p_oe_or) else $error("pin not driven");

  property p_oe_off;
    @(posedge clk) disable iff (srst)
      (!s_reg.dir[1][3] && !la_oe[1][3]) |=> !pin_oe[1][3];
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven as input");

  property p_pin_rd;
    @(posedge clk) disable iff (srst)
      (reg_rd && !s_reg.msel_s[1] && reg_addr == {`PCIO_PORT_B, `PCIO_R_PIN})
      |=> reg_rvalid && reg_rdata == $past(s_reg.sync2[1]);
  endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin read wrong");

  property p_dout_rb;
    @(posedge clk) disable iff (srst)
      (reg_wr && !reg_rd && !s_reg.msel_s[1] && reg_addr == {`PCIO_PORT_A, `PCIO_R_DOUT})
      ##1 (reg_rd && !reg_wr && !s_reg.msel_s[1] && reg_addr == {`PCIO_PORT_A, `PCIO_R_DOUT})
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_dout_rb: assert property (p_dout_rb) else $error("data out readback wrong");

  property p_omc_load;
    @(posedge clk) disable iff (srst)
      (reg_wr && !s_reg.msel_s[1] && reg_addr == {`PCIO_PORT_C, `PCIO_R_OCELL} &&
       cell_route_bc && s_reg.mask[2] == 8'h00 && cell_ld[1] == 8'h00)
      |=> s_reg.grp[1] == $past(reg_wdata);
  endproperty
  a_omc_load: assert property (p_omc_load) else $error("cell load failed");

  property p_mask;
    @(posedge clk) disable iff (srst)
      (reg_wr && reg_addr == {`PCIO_PORT_C, `PCIO_R_OCELL} && cell_ld[1] == 8'h00)
      |=> (s_reg.grp[1] & $past(s_reg.mask[2])) == ($past(s_reg.grp[1]) & $past(s_reg.mask[2]));
  endproperty
  a_mask: assert property (p_mask) else $error("masked cell loaded");

  property p_enrb;
    @(posedge clk) disable iff (srst)
      (reg_rd && !s_reg.msel_s[1] && reg_addr == {`PCIO_PORT_A, `PCIO_R_ENRB})
      |=> reg_rdata == $past(s_reg.dir[0] | la_oe[0]);
  endproperty
  a_enrb: assert property (p_enrb) else $error("enable readback wrong");

  property p_drive_c;
    @(posedge clk) disable iff (srst)
      1'b1 |=> pin_od[2] == ($past(s_reg.drive[2]) & 8'h9c) && pin_fast[2] == 8'h00;
  endproperty
  a_drive_c: assert property (p_drive_c) else $error("port c drive wrong");

  property p_msel;
    @(posedge clk) disable iff (srst)
      (s_reg.msel_s[1] && reg_wr) |=> $stable(s_reg.dir) && $stable(s_reg.dout);
  endproperty
  a_msel: assert property (p_msel) else $error("write while deselected");

  property p_sync;
    @(posedge clk) disable iff (srst)
      !$past(srst) |=> s_reg.sync2[0] == $past(pin_in[0], 2);
  endproperty
  a_sync: assert property (p_sync) else $error("pin sync depth wrong");

  property p_ecs;
    @(posedge clk) disable iff (srst)
      la_sel[3][1] |=> pin_out[3][1] == ($past(ecs_pol[0]) ? $past(ecs_term[0]) :
                                         !$past(ecs_term[0]));
  endproperty
  a_ecs: assert property (p_ecs) else $error("chip select level wrong");

  property p_c_write;
    @(posedge clk) disable iff (srst)
      reg_wr && !s_reg.msel_s[1] && reg_addr == {`PCIO_PORT_C, `PCIO_R_OCELL} && cell_route_bc;
  endproperty
  c_c_write: cover property (p_c_write);

  property p_c_ecs;
    @(posedge clk) disable iff (srst)
      pin_oe[3][2] && !pin_out[3][2];
  endproperty
  c_c_ecs: cover property (p_c_ecs);

  property p_c_od;
    @(posedge clk) disable iff (srst)
      pin_od[0][7] && !pin_oe[0][7] && s_reg.dir[0][7];
  endproperty
  c_c_od: cover property (p_c_od);

endmodule // pcio_ports

// >>> sim/pcio_mcu.sv
// mcu side model issuing register reads and writes
`timescale 1ns/1ps
module pcio_mcu (
  input  wire logic       clk,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic [5:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 6'h3f;
    reg_wdata = 8'h55;
  end
  // one cycle write pulse, lines inverted once released
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // write then read of the same register on back-to-back cycles
  task automatic wrrd(input logic [5:0] a, input logic [7:0] dw, output logic [7:0] d,
                      output logic v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = dw;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~dw;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
  // one cycle read pulse, answer taken the cycle after
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule // pcio_mcu

// >>> sim/pcio_ports_tb.sv
// self-checking bench of the coupled io ports
`timescale 1ns/1ps
`include "pcio_consts.svh"
module pcio_ports_tb;
  import pcio_pkg::*;
  logic clk, srst, reg_rd, reg_wr, reg_rvalid, msel_in, rab, rbc;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, latched_addr, pd_la;
  logic [3:0][7:0] pin_in, pin_out, pin_oe, pin_od, pin_fast, la_oe, la_sel;
  logic [1:0][7:0] cell_q;
  logic [2:0][7:0] icell_ld, icell_q;
  logic [1:0] ecs_term, ecs_pol;
  int fail_count, checks_done;
  pcio_ports dut (.clk(clk), .srst(srst), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .msel_in(msel_in), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_od(pin_od), .pin_fast(pin_fast), .la_oe(la_oe),
    .la_sel(la_sel), .latched_addr(latched_addr), .cell_route_ab(rab),
    .cell_route_bc(rbc), .cell_d(16'h0000), .cell_ld(16'h0000), .icell_ld(icell_ld),
    .ecs_term(ecs_term), .ecs_pol(ecs_pol), .cell_q(cell_q), .icell_q(icell_q),
    .pd_la(pd_la));
  pcio_mcu mcu (.clk(clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    mcu.rd(a, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, e);
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk({2'h0, `PCIO_R_DIR}, 8'h00);
    rchk({2'h1, `PCIO_R_DRIVE}, 8'h00);
    rchk({2'h1, `PCIO_R_MODE}, 8'h00);
    rchk({2'h1, `PCIO_R_MASK}, 8'h00);
    chk(pin_oe[0], 8'h00);
    chk(pin_od[0], 8'h00);
    chk(pin_fast[1], 8'h00);
  endtask
  task automatic t_dir();
    logic [7:0] d;
    logic v;
    mcu.wr({2'h0, `PCIO_R_DIR}, 8'h07);
    mcu.wrrd({2'h0, `PCIO_R_DOUT}, 8'ha5, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, 8'ha5);
    la_oe[0] = 8'h30;
    w(3);
    chk(pin_oe[0], 8'h37);
    chk(pin_out[0] & 8'h37, 8'h25);
    rchk({2'h0, `PCIO_R_ENRB}, 8'h37);
    mcu.wr({2'h0, `PCIO_R_ENRB}, 8'h00);
    rchk({2'h0, `PCIO_R_ENRB}, 8'h37);
    pin_in[0] = 8'h3c;
    w(3);
    rchk({2'h0, `PCIO_R_DOUT}, 8'ha5);
    rchk({2'h0, `PCIO_R_PIN}, 8'h3c);
  endtask
  task automatic t_cell();
    mcu.wr({2'h0, `PCIO_R_MASK}, 8'h0f);
    mcu.wr({2'h0, `PCIO_R_OCELL}, 8'hff);
    w(1);
    chk(cell_q[0], 8'hf0);
    rchk({2'h0, `PCIO_R_OCELL}, 8'hf0);
    mcu.wr({2'h2, `PCIO_R_OCELL}, 8'h3c);
    w(1);
    chk(cell_q[1], 8'h3c);
    mcu.wr({2'h2, `PCIO_R_MASK}, 8'h0f);
    mcu.wr({2'h2, `PCIO_R_OCELL}, 8'hc3);
    la_sel[2] = 8'h0f;
    w(3);
    chk(cell_q[1], 8'hcc);
    chk(pin_out[2], 8'h0c);
    rchk({2'h2, `PCIO_R_OCELL}, 8'hcc);
    rab = 1'b1;
    la_sel[1] = 8'hff;
    mcu.wr({2'h1, `PCIO_R_DIR}, 8'hff);
    w(3);
    chk(pin_out[1], 8'hf0);
    rchk({2'h1, `PCIO_R_OCELL}, 8'hf0);
  endtask
  task automatic t_icell();
    icell_ld[0] = 8'hff;
    pin_in[3] = 8'hff;
    w(4);
    icell_ld[0] = 8'h00;
    w(1);
    pin_in[0] = 8'hc3;
    w(4);
    chk(icell_q[0], 8'h3c);
    rchk({2'h0, `PCIO_R_ICELL}, 8'h3c);
    rchk({2'h0, `PCIO_R_PIN}, 8'hc3);
    chk(pd_la, 8'h06);
  endtask
  task automatic t_absent();
    mcu.wr({2'h2, `PCIO_R_MODE}, 8'hff);
    rchk({2'h2, `PCIO_R_MODE}, 8'h00);
    rchk({2'h3, `PCIO_R_OCELL}, 8'h00);
    mcu.wr({2'h3, `PCIO_R_DOUT}, 8'hff);
    rchk({2'h3, `PCIO_R_DOUT}, 8'h06);
  endtask
  task automatic t_mode();
    mcu.wr({2'h0, `PCIO_R_MODE}, 8'hff);
    w(3);
    chk(pin_out[0] & 8'h07, 8'h02);
  endtask
  task automatic t_ecs();
    la_sel[3] = 8'h06;
    mcu.wr({2'h3, `PCIO_R_DIR}, 8'h06);
    w(3);
    chk(pin_oe[3], 8'h06);
    chk(pin_out[3], 8'h02);
    ecs_pol = 2'b00;
    w(3);
    chk(pin_out[3], 8'h04);
    mcu.wr({2'h3, `PCIO_R_DIR}, 8'h00);
    la_oe[3] = 8'h04;
    w(3);
    chk(pin_oe[3], 8'h04);
    la_oe[3] = 8'h00;
  endtask
  task automatic t_drive();
    mcu.wr({2'h0, `PCIO_R_DRIVE}, 8'hff);
    mcu.wr({2'h2, `PCIO_R_DRIVE}, 8'hff);
    mcu.wr({2'h3, `PCIO_R_DRIVE}, 8'hff);
    w(3);
    chk(pin_od[0], 8'hf0);
    chk(pin_fast[0], 8'h0f);
    chk(pin_od[2], 8'h9c);
    chk(pin_fast[2], 8'h00);
    chk(pin_fast[3], 8'h06);
    chk(pin_od[3], 8'h00);
    chk(pin_oe[0], 8'h27);
  endtask
  task automatic t_msel();
    logic [7:0] d;
    logic v;
    msel_in = 1'b1;
    w(3);
    mcu.wr({2'h0, `PCIO_R_DOUT}, 8'h00);
    mcu.rd({2'h0, `PCIO_R_DOUT}, d, v);
    chk({7'h00, v}, 8'h00);
    chk(pin_out[1], 8'hf0);
    msel_in = 1'b0;
    w(3);
    rchk({2'h0, `PCIO_R_DOUT}, 8'ha5);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial begin
    srst = 1'b1;
    msel_in = 1'b0;
    pin_in = '0;
    la_oe = '0;
    la_sel = '0;
    latched_addr = 8'h5a;
    rab = 1'b0;
    rbc = 1'b1;
    icell_ld = '0;
    ecs_term = 2'b01;
    ecs_pol = 2'b11;
    fail_count = 0;
    checks_done = 0;
    w(16);
    srst = 1'b0;
    t_reset();
    t_dir();
    t_cell();
    t_icell();
    t_absent();
    t_mode();
    t_ecs();
    t_drive();
    t_msel();
    finish_test();
  end
endmodule // pcio_ports_tb
